// *** design/dacr_pkg.sv ***
// Shared constants and carrier types for the dual converter control block
package dacr_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int RES_W = 14;
  localparam int FRAME_BITS = 2 * RES_W;
  localparam int CONV_TIME_NS = 800;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWERUP_TIME_US = 100;
  localparam int POWERUP_CYCLES = (POWERUP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FIFO_DEPTH = 4;
  localparam logic [1:0] SPAN_BIP10 = 2'h0;
  localparam logic [1:0] SPAN_BIP5 = 2'h1;
  localparam logic [1:0] SPAN_UNI10 = 2'h2;
  localparam logic [1:0] SPAN_BAD = 2'h3;
  localparam logic [1:0] SPAN_RESET = SPAN_BIP10;
  localparam logic PAIR_RESET = 1'h0;
  localparam logic [RES_W-1:0] RESULT_RESET = 14'h0000;

  typedef struct packed {
    logic [RES_W-1:0] first;
    logic [RES_W-1:0] second;
  } dacr_result_t;

  typedef struct packed {
    logic conversion_start_n_n;
    logic cs_n;
    logic sclk;
    logic pair_sel;
    logic [1:0] span;
  } dacr_pins_t;

  localparam dacr_pins_t PINS_IDLE = '{conversion_start_n_n: 1'h1, cs_n: 1'h1, sclk: 1'h1, pair_sel: PAIR_RESET,
                                       span: SPAN_RESET};
endpackage : dacr_pkg

// *** design/dacr_fifo.sv ***
// Small result FIFO with valid/ready on both sides
`timescale 1ns/1ps
module dacr_fifo #(
  parameter int W = 28,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Fill side
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("dacr_fifo: DEPTH must be a power of two, at least 2");
    end
  endgenerate

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = (count != (AW + 1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge CLK) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(pop);
      count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule : dacr_fifo

// *** design/dacr_top.sv ***
// Conversion control and serial result readout for a dual 14-bit converter
`timescale 1ns/1ps
module dacr_top
  import dacr_pkg::*;
#(
  parameter int CONV_CYC = CONV_CYCLES,
  parameter int POWERUP_CYC = POWERUP_CYCLES,
  parameter int BUF_DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Host control pins, asynchronous to CLK
  input wire logic CONVERSION_START_N,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic CHAN_PAIR_SEL,
  input wire logic INPUT_SPAN_SEL_LO,
  input wire logic INPUT_SPAN_SEL_HI,
  // Raw straight-binary codes from the analog core, CLK domain
  input wire logic [RES_W-1:0] RAW_FIRST_CH1,
  input wire logic [RES_W-1:0] RAW_FIRST_CH2,
  input wire logic [RES_W-1:0] RAW_SECOND_CH1,
  input wire logic [RES_W-1:0] RAW_SECOND_CH2,
  // Status
  output logic BUSY,
  output logic ANALOG_POWER_ON,
  output logic PAIR_APPLIED,
  output logic [1:0] SPAN_APPLIED,
  // Serial data outputs with enables
  output logic SERIAL_OUT_FIRST,
  output logic SERIAL_OUT_FIRST_OE,
  output logic SERIAL_OUT_SECOND,
  output logic SERIAL_OUT_SECOND_OE
);
  localparam int CNT_MAX = (POWERUP_CYC > CONV_CYC) ? POWERUP_CYC : CONV_CYC;
  localparam int CNT_W = $clog2(CNT_MAX + 1);
  localparam int BITS_W = $clog2(FRAME_BITS + 1);
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);
  localparam logic [CNT_W-1:0] WARM_LAST = CNT_W'(POWERUP_CYC - 1);
  localparam logic [BITS_W-1:0] BITS_FULL = BITS_W'(FRAME_BITS);

  generate
    if (CONV_CYC < 1 || POWERUP_CYC < 1 || BUF_DEPTH < 2) begin : g_bad_param
      $error("dacr_top: counts must be at least 1 and buffer depth at least 2");
    end
  endgenerate

  typedef enum logic [1:0] {ST_WARM, ST_IDLE, ST_CONV, ST_SHUT} dacr_state_t;

  // Pin synchronisers; stage 1 feeds only stage 2
  dacr_pins_t pin_raw;
  dacr_pins_t pin_s1;
  dacr_pins_t pin_s2;
  dacr_pins_t pin_prev;

  assign pin_raw = '{conversion_start_n_n: CONVERSION_START_N, cs_n: CS_N, sclk: SCLK, pair_sel: CHAN_PAIR_SEL,
                     span: {INPUT_SPAN_SEL_HI, INPUT_SPAN_SEL_LO}};

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pin_s1 <= PINS_IDLE;
      pin_s2 <= PINS_IDLE;
      pin_prev <= PINS_IDLE;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_prev <= pin_s2;
    end
  end

  wire conversion_start_n_fall = pin_prev.conversion_start_n_n & ~pin_s2.conversion_start_n_n;
  wire conversion_start_n_rise = ~pin_prev.conversion_start_n_n & pin_s2.conversion_start_n_n;
  wire cs_fall = pin_prev.cs_n & ~pin_s2.cs_n;
  wire cs_rise = ~pin_prev.cs_n & pin_s2.cs_n;
  wire cs_low = ~pin_s2.cs_n;
  wire sclk_fall = pin_prev.sclk & ~pin_s2.sclk;
  wire pair_pin = pin_s2.pair_sel;
  wire [1:0] span_pin = pin_s2.span;

  // Conversion sequencer
  dacr_state_t state;
  dacr_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic fifo_in_ready;

  wire start_ok = (state == ST_IDLE) & conversion_start_n_fall;
  wire conv_end = (state == ST_CONV) & (cnt == CONV_LAST);
  // Back-pressure: a full buffer stretches busy instead of dropping a result
  wire conv_done = conv_end & fifo_in_ready;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      ST_WARM: begin
        // Start must stay high for the whole power-up wait
        if (!pin_s2.conversion_start_n_n) begin
          next_cnt = '0;
        end else if (cnt == WARM_LAST) begin
          next_state = ST_IDLE;
        end else begin
          next_cnt = cnt + CNT_W'(1);
        end
      end
      ST_IDLE: begin
        if (start_ok) begin
          next_state = ST_CONV;
          next_cnt = '0;
        end
      end
      ST_CONV: begin
        // Timed from CLK only; serial clock plays no part
        if (cnt != CONV_LAST) begin
          next_cnt = cnt + CNT_W'(1);
        end else if (fifo_in_ready) begin
          next_state = pin_s2.conversion_start_n_n ? ST_IDLE : ST_SHUT;
          next_cnt = '0;
        end
      end
      ST_SHUT: begin
        if (conversion_start_n_rise) begin
          next_state = ST_WARM;
          next_cnt = '0;
        end
      end
      default: begin
        next_state = ST_WARM;
        next_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state <= ST_WARM;
      cnt <= '0;
      BUSY <= 1'h0;
      ANALOG_POWER_ON <= 1'h1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      BUSY <= (next_state == ST_CONV);
      ANALOG_POWER_ON <= (next_state != ST_SHUT);
    end
  end

  // Sampling: the pair in force now is used, the pin value is kept for the next one
  wire [RES_W-1:0] pick_first = PAIR_APPLIED ? RAW_FIRST_CH2 : RAW_FIRST_CH1;
  wire [RES_W-1:0] pick_second = PAIR_APPLIED ? RAW_SECOND_CH2 : RAW_SECOND_CH1;
  wire span_legal = (span_pin != SPAN_BAD);
  dacr_result_t sample;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sample <= '{first: RESULT_RESET, second: RESULT_RESET};
      PAIR_APPLIED <= PAIR_RESET;
      SPAN_APPLIED <= SPAN_RESET;
    end else if (start_ok) begin
      // Offset binary to two's complement by inverting the MSB
      sample.first <= {~pick_first[RES_W-1], pick_first[RES_W-2:0]};
      sample.second <= {~pick_second[RES_W-1], pick_second[RES_W-2:0]};
      PAIR_APPLIED <= pair_pin;
      // Forbidden span code keeps the previous span
      SPAN_APPLIED <= span_legal ? span_pin : SPAN_APPLIED;
    end
  end

  // Result buffer
  dacr_result_t fifo_out;
  logic fifo_out_valid;
  logic [BITS_W-1:0] bits;
  wire fifo_out_ready = pin_s2.cs_n | (bits == '0);
  wire pop = fifo_out_valid & fifo_out_ready;

  dacr_fifo #(
    .W(FRAME_BITS),
    .DEPTH(BUF_DEPTH)
  ) u_fifo (
    .CLK(CLK),
    .RST(RST),
    .in_data(sample),
    .in_valid(conv_end),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready)
  );

  // Last result held for any number of reads, also in shutdown
  dacr_result_t hold;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      hold <= '{first: RESULT_RESET, second: RESULT_RESET};
    end else if (pop) begin
      hold <= fifo_out;
    end
  end

  // Serial shifter
  dacr_result_t src;
  assign src = pop ? fifo_out : hold;
  wire src_first_msb = src.first[RES_W-1];
  // A new result may replace the frame only before the first shift
  wire load = cs_fall | (cs_low & pop & (bits == '0));
  wire shift = cs_low & ~cs_fall & sclk_fall & SERIAL_OUT_FIRST_OE;
  logic [FRAME_BITS-1:0] sh_first;
  logic [FRAME_BITS-1:0] sh_second;
  logic oe;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      oe <= 1'h0;
      bits <= '0;
      sh_first <= '0;
      sh_second <= '0;
    end else if (cs_rise) begin
      oe <= 1'h0;
      bits <= '0;
    end else if (load) begin
      oe <= 1'h1;
      bits <= '0;
      sh_first <= {src.first, src.second};
      sh_second <= {src.second, src.first};
    end else if (shift) begin
      sh_first <= {sh_first[FRAME_BITS-2:0], 1'h0};
      sh_second <= {sh_second[FRAME_BITS-2:0], 1'h0};
      // Saturates at 28 so bits stays nonzero until select rises and no buffered result can reload the frame
      bits <= (bits == BITS_FULL) ? bits : bits + BITS_W'(1);
    end
  end

  assign SERIAL_OUT_FIRST = sh_first[FRAME_BITS-1];
  assign SERIAL_OUT_SECOND = sh_second[FRAME_BITS-1];
  assign SERIAL_OUT_FIRST_OE = oe;
  assign SERIAL_OUT_SECOND_OE = oe;

  // Helper: length of the current busy pulse, saturating so a long stall never wraps
  logic [CNT_W:0] busy_len;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      busy_len <= '0;
    end else begin
      busy_len <= !BUSY ? '0 : (&busy_len) ? busy_len : busy_len + (CNT_W + 1)'(1);
    end
  end

  sequence s_start;
    start_ok;
  endsequence

  sequence s_frame_open;
    SERIAL_OUT_FIRST_OE && SERIAL_OUT_SECOND_OE && bits == '0;
  endsequence

  property p_start_busy;
    @(posedge CLK) disable iff (RST) s_start |=> BUSY && state == ST_CONV;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("busy did not rise after start");

  property p_busy_len;
    @(posedge CLK) disable iff (RST) $fell(BUSY) |-> $past(busy_len) >= (CNT_W + 1)'(CONV_CYC - 1);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy pulse shorter than conversion");

  property p_shutdown;
    @(posedge CLK) disable iff (RST) (conv_done && !pin_s2.conversion_start_n_n) |=> !ANALOG_POWER_ON && !BUSY;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("no shutdown with start low at end");

  property p_cs_open;
    @(posedge CLK) disable iff (RST) (cs_fall && !pop) |=> s_frame_open and SERIAL_OUT_FIRST == $past(src_first_msb);
  endproperty
  a_cs_open: assert property (p_cs_open) else $error("select fall did not present MSB");

  property p_shift_count;
    @(posedge CLK) disable iff (RST) (shift && !load && bits != BITS_FULL) |=> bits == $past(bits) + BITS_W'(1);
  endproperty
  a_shift_count: assert property (p_shift_count) else $error("bit count did not advance");

  property p_coincide;
    @(posedge CLK) disable iff (RST) (cs_fall && sclk_fall) |=> s_frame_open;
  endproperty
  a_coincide: assert property (p_coincide) else $error("coincident clock fall was counted");

  property p_stay_driven;
    @(posedge CLK) disable iff (RST) (oe && cs_low) |=> oe;
  endproperty
  a_stay_driven: assert property (p_stay_driven) else $error("outputs floated with select low");

  property p_cs_float;
    @(posedge CLK) disable iff (RST) cs_rise |=> !SERIAL_OUT_FIRST_OE && !SERIAL_OUT_SECOND_OE;
  endproperty
  a_cs_float: assert property (p_cs_float) else $error("outputs not floated on select rise");

  property p_second_word;
    @(posedge CLK) disable iff (RST)
      load |=> sh_first[RES_W-1:0] == $past(src.second) && sh_second[FRAME_BITS-1:RES_W] == $past(src.second);
  endproperty
  a_second_word: assert property (p_second_word) else $error("second word mismatch");

  property p_pair;
    @(posedge CLK) disable iff (RST) s_start |=> PAIR_APPLIED == $past(pair_pin);
  endproperty
  a_pair: assert property (p_pair) else $error("pair select not captured at busy rise");

  property p_wake;
    @(posedge CLK) disable iff (RST) (state == ST_SHUT && conversion_start_n_rise) |=> ANALOG_POWER_ON && state == ST_WARM;
  endproperty
  a_wake: assert property (p_wake) else $error("start rise did not wake");
endmodule : dacr_top

// *** tb/dacr_host.sv ***
// Host-side model: conversion start, chip select and serial clock
`timescale 1ns/1ps
module dacr_host (
  // Clock, device status and serial data lines
  input wire logic clk,
  input wire logic busy,
  input wire logic line_first,
  input wire logic line_second,
  // Pins toward the device
  output logic conv_n,
  output logic cs_n,
  output logic sclk
);
  initial begin
    conv_n = 1'h1;
    cs_n = 1'h1;
    sclk = 1'h1;
  end

  task automatic set_pins(input logic c, input logic s);
    conv_n <= c;
    cs_n <= s;
    @(posedge clk);
  endtask : set_pins

  // A nonzero drop_cs raises select mid-conversion so a stalled buffer can drain
  task automatic convert(input logic keep_low, input int drop_cs, output int len);
    int n;
    n = 0;
    len = 0;
    conv_n <= 1'h0;
    while (busy !== 1'h1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    conv_n <= !keep_low;
    while (busy === 1'h1 && len < 500) begin
      @(posedge clk);
      len++;
      if (len == drop_cs) cs_n <= 1'h1;
    end
    repeat (4) @(posedge clk);
  endtask : convert

  // Bits land right-aligned; each sample is taken just before the falling edge that shifts it
  task automatic read(input int nbits, input logic clash, output logic [27:0] a, output logic [27:0] b);
    a = '0;
    b = '0;
    cs_n <= 1'h0;
    sclk <= !clash;
    repeat (4) @(posedge clk);
    sclk <= 1'h1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      a = {a[26:0], line_first};
      b = {b[26:0], line_second};
      sclk <= 1'h0;
      repeat (4) @(posedge clk);
      sclk <= 1'h1;
      repeat (4) @(posedge clk);
    end
  endtask : read

  task automatic release_cs();
    cs_n <= 1'h1;
    repeat (6) @(posedge clk);
  endtask : release_cs
endmodule : dacr_host

// *** tb/tb_dacr_top.sv ***
// Self-checking bench for the dual converter control block
`timescale 1ns/1ps
module tb_dacr_top;
  import dacr_pkg::*;
  localparam int PU_CYC = 4;
  localparam logic [13:0] VALS [4] = '{14'h0000, 14'h3FFF, 14'h2000, 14'h1ABC};
  logic CLK = 1'h0;
  logic RST = 1'h1;
  logic pair = 1'h0;
  logic prev = PAIR_RESET;
  logic [1:0] span = 2'h0;
  logic [13:0] f1 = '0, f2 = '0, s1 = '0, s2 = '0;
  logic [27:0] a, b, w;
  int len;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  wire busy, pwr, pair_ap, out_f, oe_f, out_s, oe_s, conv_n, cs_n, sclk;
  wire [1:0] span_ap;
  // Released lines float so a read of a floating output never passes
  wire line_f = oe_f ? out_f : 1'bz;
  wire line_s = oe_s ? out_s : 1'bz;

  always #50 CLK = ~CLK;

  dacr_top #(.POWERUP_CYC(PU_CYC)) i_dut (
    .CLK(CLK), .RST(RST), .CONVERSION_START_N(conv_n), .CS_N(cs_n), .SCLK(sclk),
    .CHAN_PAIR_SEL(pair), .INPUT_SPAN_SEL_LO(span[0]), .INPUT_SPAN_SEL_HI(span[1]),
    .RAW_FIRST_CH1(f1), .RAW_FIRST_CH2(f2), .RAW_SECOND_CH1(s1), .RAW_SECOND_CH2(s2),
    .BUSY(busy), .ANALOG_POWER_ON(pwr), .PAIR_APPLIED(pair_ap), .SPAN_APPLIED(span_ap),
    .SERIAL_OUT_FIRST(out_f), .SERIAL_OUT_FIRST_OE(oe_f),
    .SERIAL_OUT_SECOND(out_s), .SERIAL_OUT_SECOND_OE(oe_s)
  );

  dacr_host i_host (
    .clk(CLK), .busy(busy), .line_first(line_f), .line_second(line_s),
    .conv_n(conv_n), .cs_n(cs_n), .sclk(sclk)
  );

  task automatic wrap_up();
    if (bad_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [27:0] seen, input logic [27:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [13:0] tc(input logic [13:0] r);
    return {~r[13], r[12:0]};
  endfunction : tc

  function automatic logic [27:0] expect_word(input logic p);
    return p ? {tc(f2), tc(s2)} : {tc(f1), tc(s1)};
  endfunction : expect_word

  task automatic frame(input logic clash, input logic [27:0] x);
    i_host.read(28, clash, a, b);
    repeat (10) @(posedge CLK);
    check(a, x);
    check(b, {x[13:0], x[27:14]});
    check(28'({oe_f, oe_s}), 28'h3);
    i_host.release_cs();
    check(28'({oe_f, oe_s}), 28'h0);
  endtask : frame

  always @(posedge CLK) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      wrap_up();
    end
  end

  initial begin
    repeat (5) @(posedge CLK);
    RST <= 1'h0;
    @(posedge CLK);
    check(28'({busy, oe_f, oe_s, pair_ap, span_ap, pwr}), 28'h01);
    repeat (PU_CYC + 6) @(posedge CLK);
    for (int k = 0; k < 4; k++) begin
      f1 <= VALS[k];
      f2 <= ~VALS[k];
      s1 <= VALS[k] ^ 14'h1555;
      s2 <= VALS[k] ^ 14'h2AAA;
      pair <= k[0];
      span <= k[1:0];
      @(posedge CLK);
      i_host.convert(1'h0, 0, len);
      check(28'(len), 28'(CONV_CYCLES));
      check(28'(pair_ap), 28'(k[0]));
      check(28'(span_ap), 28'((k == 3) ? SPAN_UNI10 : k[1:0]));
      check(28'(pwr), 28'h1);
      w = expect_word(prev);
      prev = k[0];
      frame(k[0], w);
    end
    // One bit shifted keeps the shifter busy, so results pile up in the buffer
    pair <= 1'h0;
    i_host.read(1, 1'h0, a, b);
    for (int k = 0; k < 4; k++) begin
      i_host.convert(1'h0, 0, len);
      check(28'(len), 28'(CONV_CYCLES));
    end
    i_host.convert(1'h0, 40, len);
    check(28'(len >= 40), 28'h1);
    repeat (10) @(posedge CLK);
    frame(1'h0, expect_word(1'h0));
    f1 <= 14'h3C3C;
    s1 <= 14'h0555;
    i_host.set_pins(1'h1, 1'h0);
    i_host.convert(1'h1, 0, len);
    check(28'(pwr), 28'h0);
    w = expect_word(1'h0);
    i_host.read(14, 1'h0, a, b);
    check(a, 28'(w[27:14]));
    i_host.release_cs();
    frame(1'h0, w);
    i_host.set_pins(1'h1, 1'h1);
    i_host.set_pins(1'h0, 1'h1);
    for (int i = 0; i < 12; i++) begin
      check(28'(busy), 28'h0);
      @(posedge CLK);
    end
    check(28'(pwr), 28'h1);
    i_host.set_pins(1'h1, 1'h1);
    repeat (PU_CYC + 6) @(posedge CLK);
    i_host.convert(1'h0, 0, len);
    check(28'(len), 28'(CONV_CYCLES));
    wrap_up();
  end
endmodule : tb_dacr_top
